// ==== rtl/icc_top.sv ====
/*
 * Input capture channel: control register, capture buffer, interrupt logic.
 * Assumes a synchronous capture pin, free-running timer counts and CPU power-state inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_top
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Capture input and timers
    input wire logic cap_pin,
    input wire logic [15:0] timer_two_count,
    input wire logic [15:0] timer_three_count,
    // CPU power state
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    // Interrupt
    output logic irq
);
    import icc_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic idle_halt_select;
        logic timebase_select;
        logic [1:0] captures_per_interrupt;
        logic capture_overflow_flag;
        logic [2:0] capture_mode_select;
        logic [1:0] cap_cnt;
        logic [ICC_IRQ_W-1:0] irq_stat;
        logic [ICC_IRQ_W-1:0] irq_mask;
        logic [15:0] rdata;
        logic irq;
    } icc_st_t;

    icc_st_t st_ff;
    icc_st_t nxt_st;
    icc_fifo_if fif ();
    logic rise;
    logic fall;
    logic cap_evt;
    logic run;
    logic capture_on;
    logic wake_mode;
    logic buffer_nonempty_flag;
    logic [15:0] ctrl_view;
    logic [ICC_IRQ_W-1:0] evt;
    logic [ICC_IRQ_W-1:0] w1c;

    assign wake_mode = (st_ff.capture_mode_select == ICC_M_WAKE);
    // Capture modes are 001..101; 000 and 110 leave the channel idle.
    assign capture_on = (st_ff.capture_mode_select != ICC_M_OFF) &&
        (st_ff.capture_mode_select != ICC_M_UNUSED) && !wake_mode;
    assign run = capture_on && !(st_ff.idle_halt_select && cpu_idle);
    assign buffer_nonempty_flag = !fif.empty;

    // ****************************************
    // Edge detection and buffer
    // ****************************************
    icc_edge u_edge
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(run),
        .mode(st_ff.capture_mode_select),
        .cap_pin(cap_pin),
        .rise(rise),
        .fall(fall),
        .event_pulse(cap_evt)
    );

    icc_fifo u_fifo
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .fb(fif.buf_side)
    );

    assign fif.push = cap_evt;
    assign fif.push_data = st_ff.timebase_select ? timer_two_count : timer_three_count;
    assign fif.pop = reg_rd && (reg_addr == ICC_ADDR_BUF);
    assign fif.flush = !capture_on;

    // Unimplemented bits are simply never assembled into the view.
    always_comb
    begin
        ctrl_view = 16'h0000;
        ctrl_view[ICC_BIT_IDLE_HALT] = st_ff.idle_halt_select;
        ctrl_view[ICC_BIT_TIMEBASE] = st_ff.timebase_select;
        ctrl_view[ICC_POS_CPI +: 2] = st_ff.captures_per_interrupt;
        // The stored flag clears one cycle after the buffer drains, so it is gated here.
        // Without the gate, a read right after the last pop would show overflow with an empty buffer.
        ctrl_view[ICC_BIT_OVF] = st_ff.capture_overflow_flag && buffer_nonempty_flag;
        ctrl_view[ICC_BIT_BNE] = buffer_nonempty_flag;
        ctrl_view[ICC_POS_MODE +: 3] = st_ff.capture_mode_select;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_st = st_ff;
        evt = '0;
        w1c = '0;

        // Control writes; only writable bits are taken, status bits are read-only.
        if (reg_wr && (reg_addr == ICC_ADDR_CTRL))
        begin
            nxt_st.idle_halt_select = reg_wdata[ICC_BIT_IDLE_HALT] & ICC_CTRL_WMASK[ICC_BIT_IDLE_HALT];
            nxt_st.timebase_select = reg_wdata[ICC_BIT_TIMEBASE];
            nxt_st.captures_per_interrupt = reg_wdata[ICC_POS_CPI +: 2];
            nxt_st.capture_mode_select = reg_wdata[ICC_POS_MODE +: 3];
        end
        if (reg_wr && (reg_addr == ICC_ADDR_IRQ_MASK))
        begin
            nxt_st.irq_mask = reg_wdata[ICC_IRQ_W-1:0];
        end
        if (reg_wr && (reg_addr == ICC_ADDR_IRQ_STAT))
        begin
            w1c = reg_wdata[ICC_IRQ_W-1:0];
        end

        // Capture counting toward the interrupt.
        if (!run)
        begin
            nxt_st.cap_cnt = 2'b00;
        end
        else if (cap_evt)
        begin
            if (st_ff.capture_mode_select == ICC_M_BOTH)
            begin
                evt[ICC_IRQ_CAP] = 1'b1;
                nxt_st.cap_cnt = 2'b00;
            end
            else if (st_ff.cap_cnt == st_ff.captures_per_interrupt)
            begin
                evt[ICC_IRQ_CAP] = 1'b1;
                nxt_st.cap_cnt = 2'b00;
            end
            else
            begin
                nxt_st.cap_cnt = st_ff.cap_cnt + 2'b01;
            end
        end

        // Overflow: a capture lost to a full buffer.
        if (!capture_on || (fif.empty && !cap_evt))
        begin
            nxt_st.capture_overflow_flag = 1'b0;
        end
        if (cap_evt && fif.full)
        begin
            nxt_st.capture_overflow_flag = 1'b1;
            evt[ICC_IRQ_OVF] = 1'b1;
        end

        // Wake mode ignores every other control bit.
        if (wake_mode && (cpu_sleep || cpu_idle) && rise)
        begin
            evt[ICC_IRQ_WAKE] = 1'b1;
        end

        // Set beats clear so a same-cycle event is never lost.
        nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | evt;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        // Registered read data, valid only the cycle after the strobe.
        nxt_st.rdata = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                ICC_ADDR_CTRL: nxt_st.rdata = ctrl_view;
                ICC_ADDR_BUF: nxt_st.rdata = fif.empty ? 16'h0000 : fif.head;
                ICC_ADDR_IRQ_STAT: nxt_st.rdata = {13'h0000, st_ff.irq_stat};
                ICC_ADDR_IRQ_MASK: nxt_st.rdata = {13'h0000, st_ff.irq_mask};
                default: nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign irq = st_ff.irq;
endmodule
`default_nettype wire

// ==== rtl/icc_pkg.sv ====
/*
 * Shared constants and types of the input capture control block.
 * Assumes a single 250 MHz clock and 16-bit timer counts supplied from outside.
 */
package icc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ICC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] ICC_ADDR_BUF = 4'h1;
    localparam logic [3:0] ICC_ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] ICC_ADDR_IRQ_MASK = 4'h3;

    localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ICC_CTRL_WMASK = 16'h20E7;
    localparam int ICC_BIT_IDLE_HALT = 13;
    localparam int ICC_BIT_TIMEBASE = 7;
    localparam int ICC_POS_CPI = 5;
    localparam int ICC_BIT_OVF = 4;
    localparam int ICC_BIT_BNE = 3;
    localparam int ICC_POS_MODE = 0;

    // Interrupt status bits: capture interrupt, overflow, wake edge during sleep or idle.
    localparam int ICC_IRQ_W = 3;
    localparam int ICC_IRQ_CAP = 0;
    localparam int ICC_IRQ_OVF = 1;
    localparam int ICC_IRQ_WAKE = 2;

    // ****************************************
    // Buffer and prescaler sizes
    // ****************************************
    localparam int ICC_DEPTH = 4;
    localparam int ICC_PTR_W = 2;
    localparam logic [3:0] ICC_PRE4_LAST = 4'h3;
    localparam logic [3:0] ICC_PRE16_LAST = 4'hF;

    typedef enum logic [2:0] {
        ICC_M_OFF = 3'h0,
        ICC_M_BOTH = 3'h1,
        ICC_M_FALL = 3'h2,
        ICC_M_RISE = 3'h3,
        ICC_M_RISE4 = 3'h4,
        ICC_M_RISE16 = 3'h5,
        ICC_M_UNUSED = 3'h6,
        ICC_M_WAKE = 3'h7
    } icc_mode_t;

endpackage

// ==== rtl/icc_fifo_if.sv ====
/*
 * Interface carrying push and pop traffic between the control block and its capture buffer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface icc_fifo_if;
    logic push;
    logic [15:0] push_data;
    logic pop;
    logic flush;
    logic [15:0] head;
    logic full;
    logic empty;

    modport ctrl (output push, output push_data, output pop, output flush, input head, input full, input empty);
    modport buf_side (input push, input push_data, input pop, input flush, output head, output full, output empty);
endinterface
`default_nettype wire

// ==== rtl/icc_fifo.sv ====
/*
 * Four-entry capture buffer holding latched timer counts.
 * Pushes while full are dropped here and do not enter the buffer; such captures are counted as overflow upstream.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_fifo
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Buffer port
    icc_fifo_if.buf_side fb
);
    import icc_pkg::*;

    typedef struct packed {
        logic [ICC_PTR_W-1:0] wp;
        logic [ICC_PTR_W-1:0] rp;
        logic [ICC_PTR_W:0] cnt;
    } icc_fifo_st_t;

    icc_fifo_st_t st_ff;
    icc_fifo_st_t nxt_st;
    logic [15:0] mem_ff [ICC_DEPTH];
    logic do_push;
    logic do_pop;

    assign fb.full = (st_ff.cnt == (ICC_PTR_W+1)'(ICC_DEPTH));
    assign fb.empty = (st_ff.cnt == '0);
    assign fb.head = mem_ff[st_ff.rp];
    assign do_push = fb.push && !fb.full && !fb.flush;
    assign do_pop = fb.pop && !fb.empty && !fb.flush;

    always_comb
    begin
        nxt_st = st_ff;
        if (fb.flush)
        begin
            nxt_st = '0;
        end
        else
        begin
            if (do_push)
            begin
                nxt_st.wp = st_ff.wp + 1'b1;
            end
            if (do_pop)
            begin
                nxt_st.rp = st_ff.rp + 1'b1;
            end
            nxt_st.cnt = st_ff.cnt + (ICC_PTR_W+1)'(do_push) - (ICC_PTR_W+1)'(do_pop);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Storage has no reset: content is only visible after a push.
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
        begin
            mem_ff[st_ff.wp] <= fb.push_data;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/icc_edge.sv ====
/*
 * Edge detector and rising-edge prescaler for the capture input.
 * Assumes the capture pin is already synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_edge
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic [2:0] mode,
    // Pin
    input wire logic cap_pin,
    // Events
    output logic rise,
    output logic fall,
    output logic event_pulse
);
    import icc_pkg::*;

    typedef struct packed {
        logic pin_d;
        logic [3:0] pre;
    } icc_edge_st_t;

    icc_edge_st_t st_ff;
    icc_edge_st_t nxt_st;
    logic pre_hit;

    assign rise = cap_pin && !st_ff.pin_d;
    assign fall = !cap_pin && st_ff.pin_d;
    assign pre_hit = (mode == ICC_M_RISE4) ? (st_ff.pre == ICC_PRE4_LAST) : (st_ff.pre == ICC_PRE16_LAST);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pin_d = cap_pin;
        event_pulse = 1'b0;
        if (!run)
        begin
            // A halted or disabled channel restarts its prescaler from zero.
            nxt_st.pre = '0;
        end
        else
        begin
            case (mode)
                ICC_M_BOTH: event_pulse = rise || fall;
                ICC_M_FALL: event_pulse = fall;
                ICC_M_RISE: event_pulse = rise;
                ICC_M_RISE4, ICC_M_RISE16:
                begin
                    if (rise)
                    begin
                        event_pulse = pre_hit;
                        nxt_st.pre = pre_hit ? 4'h0 : st_ff.pre + 4'h1;
                    end
                end
                default: event_pulse = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// ==== dv/icc_pin_src.sv ====
/*
 * Model of the external capture pin source.
 * Assumes the pin is synchronous to sys_clk, as the capture block expects.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_pin_src
(
    // Clock
    input wire logic sys_clk,
    // Pin
    output var logic cap_pin
);
    initial cap_pin = 1'b0;

    // Each pulse is long enough for the edge detector and the interrupt register to settle.
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            cap_pin <= 1'b1;
            repeat (3) @(posedge sys_clk);
            cap_pin <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/icc_assertions.sv ====
/*
 * Port checker for the capture block.
 * Assumes it is bound to icc_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_assertions
    import icc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Power state and interrupt
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic irq
);
    logic [2:0] mode_ff;
    logic [2:0] mask_ff;
    logic low_pwr;

    assign low_pwr = cpu_sleep | cpu_idle;

    // Shadow copies of the mode and mask, kept from the writes seen on the port.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_ff <= 3'h0;
            mask_ff <= 3'h0;
        end
        else if (reg_wr && reg_addr == ICC_ADDR_CTRL)
            mode_ff <= reg_wdata[2:0];
        else if (reg_wr && reg_addr == ICC_ADDR_IRQ_MASK)
            mask_ff <= reg_wdata[2:0];
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_ctrl_unimpl: assert property ($past(reg_rd) && $past(reg_addr) == ICC_ADDR_CTRL |->
        reg_rdata[15:14] == 2'h0 && reg_rdata[12:8] == 5'h00) else $error("unused control bits set");
    a_ctrl_rdback: assert property (reg_wr && reg_addr == ICC_ADDR_CTRL ##1 reg_rd && reg_addr == ICC_ADDR_CTRL
        |=> (reg_rdata & ICC_CTRL_WMASK) == ($past(reg_wdata, 2) & ICC_CTRL_WMASK)) else $error("control readback");
    a_ovf_needs_bne: assert property ($past(reg_rd) && $past(reg_addr) == ICC_ADDR_CTRL
        && reg_rdata[ICC_BIT_OVF] |-> reg_rdata[ICC_BIT_BNE]) else $error("overflow with empty buffer");
    a_irq_masked: assert property (irq |-> $past(mask_ff) != 3'h0 || mask_ff != 3'h0)
        else $error("interrupt with all sources masked");
    a_irq_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
        else $error("interrupt dropped without a write");
    a_off_quiet: assert property ($rose(irq) && $past(mode_ff) inside {3'h0, 3'h6} && $past(mode_ff, 2) inside
        {3'h0, 3'h6} |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("event while channel off");
    a_wake_gate: assert property ($rose(irq) && $past(mode_ff) == 3'h7 && $past(mode_ff, 2) == 3'h7 &&
        !$past(reg_wr) && !$past(reg_wr, 2) |-> $past(low_pwr) || $past(low_pwr, 2)) else $error("wake while awake");

    c_irq: cover property ($rose(irq));
    c_wake: cover property ($rose(irq) && mode_ff == 3'h7);
    c_buf: cover property ($past(reg_rd) && $past(reg_addr) == ICC_ADDR_BUF && reg_rdata != 16'h0000);
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
 * Self-checking testbench for the capture block.
 * Assumes the pin model and the checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import icc_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic cap_pin;
    logic [15:0] t2;
    logic [15:0] t3;
    logic cpu_idle;
    logic cpu_sleep;
    logic irq;
    logic [15:0] cw;
    int miscompares = 0;
    int n_tests = 0;
    int pc[8] = '{2, 2, 3, 3, 8, 16, 3, 3};
    int ec[8] = '{0, 4, 3, 3, 2, 1, 0, 0};

    always #2 sys_clk = ~sys_clk;

    icc_top dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_pin(cap_pin), .timer_two_count(t2),
        .timer_three_count(t3), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
    icc_pin_src pin (.sys_clk(sys_clk), .cap_pin(cap_pin));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // A following write raises the strobe again just after this edge, never in the same time step.
        #1;
    endtask

    task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask

    task automatic ic(input logic e);
        #1 chk("irq", {15'h0000, irq}, {15'h0000, e});
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        results();
    end

    initial
    begin
        nrst <= 1'b0;
        reg_addr <= 4'h0;
        reg_wdata <= 16'h0000;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        t2 <= 16'h2222;
        t3 <= 16'h3333;
        cpu_idle <= 1'b0;
        cpu_sleep <= 1'b0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rc(ICC_ADDR_CTRL, ICC_CTRL_RESET, "ctrl");
        rc(ICC_ADDR_IRQ_STAT, 16'h0000, "stat");
        wr(4'h9, 16'hFFFF);
        wr(ICC_ADDR_CTRL, 16'hFFFF);
        rc(ICC_ADDR_CTRL, 16'h20E7, "ctrl");
        rc(4'h9, 16'h0000, "unmapped");
        wr(ICC_ADDR_CTRL, 16'h0000);
        $display("test registers done");
        for (int m = 0; m < 8; m++)
        begin
            // Fresh timer values per mode, so a stale or wrong capture source shows up.
            t2 <= 16'h2200 + 16'(m);
            t3 <= 16'h3300 + 16'(m);
            cw = 16'((m % 2) << 7) | 16'(m);
            wr(ICC_ADDR_CTRL, cw);
            pin.pulses(pc[m]);
            rc(ICC_ADDR_CTRL, cw | (ec[m] > 0 ? 16'h0008 : 16'h0000), "bne");
            repeat (ec[m]) rc(ICC_ADDR_BUF, (m % 2) ? t2 : t3, "capture");
            rc(ICC_ADDR_BUF, 16'h0000, "empty");
            wr(ICC_ADDR_CTRL, 16'h0000);
        end
        $display("test modes done");
        wr(ICC_ADDR_CTRL, 16'h0003);
        for (int i = 0; i < 5; i++)
        begin
            t3 <= 16'h0100 + 16'(i);
            pin.pulses(1);
        end
        rc(ICC_ADDR_CTRL, 16'h001B, "ovf");
        rc(ICC_ADDR_IRQ_STAT, 16'h0003, "stat");
        for (int i = 0; i < 4; i++)
            rc(ICC_ADDR_BUF, 16'h0100 + 16'(i), "order");
        rc(ICC_ADDR_CTRL, 16'h0003, "ovf clear");
        wr(ICC_ADDR_IRQ_STAT, 16'h0007);
        rc(ICC_ADDR_IRQ_STAT, 16'h0000, "w1c");
        $display("test overflow done");
        wr(ICC_ADDR_IRQ_MASK, 16'h0001);
        for (int c = 0; c < 5; c++)
        begin
            wr(ICC_ADDR_CTRL, 16'h0000);
            wr(ICC_ADDR_IRQ_STAT, 16'h0007);
            wr(ICC_ADDR_CTRL, c < 4 ? 16'(c << 5) | 16'h0003 : 16'h0061);
            pin.pulses(c % 4);
            ic(1'b0);
            pin.pulses(1);
            ic(1'b1);
        end
        $display("test interrupt count done");
        wr(ICC_ADDR_CTRL, 16'h0000);
        cpu_idle <= 1'b1;
        wr(ICC_ADDR_CTRL, 16'h2003);
        pin.pulses(1);
        rc(ICC_ADDR_CTRL, 16'h2003, "halt");
        wr(ICC_ADDR_CTRL, 16'h0003);
        pin.pulses(1);
        rc(ICC_ADDR_CTRL, 16'h000B, "run");
        cpu_idle <= 1'b0;
        $display("test idle done");
        wr(ICC_ADDR_CTRL, 16'h0000);
        wr(ICC_ADDR_IRQ_STAT, 16'h0007);
        wr(ICC_ADDR_IRQ_MASK, 16'h0000);
        wr(ICC_ADDR_CTRL, 16'h0007);
        pin.pulses(1);
        rc(ICC_ADDR_IRQ_STAT, 16'h0000, "awake");
        cpu_sleep <= 1'b1;
        pin.pulses(1);
        ic(1'b0);
        rc(ICC_ADDR_IRQ_STAT, 16'h0004, "wake");
        wr(ICC_ADDR_CTRL, 16'h0000);
        wr(ICC_ADDR_IRQ_MASK, 16'h0004);
        @(posedge sys_clk);
        ic(1'b1);
        wr(ICC_ADDR_IRQ_STAT, 16'h0004);
        @(posedge sys_clk);
        ic(1'b0);
        wr(ICC_ADDR_CTRL, 16'h0007);
        pin.pulses(1);
        ic(1'b1);
        cpu_sleep <= 1'b0;
        $display("test wake done");
        results();
    end
endmodule

bind icc_top icc_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
`default_nettype wire
